//--- rtl/gpbcd_map.svh
// Purpose: offsets, field positions and reset values of the port block
// Assumes: APB byte address is four times the register index
// Notes: included by the port module and its bench
`ifndef GPBCD_MAP_SVH
`define GPBCD_MAP_SVH
`define GPBCD_IDX_DATA_B 6'h01
`define GPBCD_IDX_DATA_C 6'h02
`define GPBCD_IDX_DATA_D 6'h03
`define GPBCD_IDX_DIR_B 6'h04
`define GPBCD_IDX_DIR_C 6'h05
`define GPBCD_IDX_DIR_D 6'h06
`define GPBCD_IDX_HDRV_B 6'h0C
`define GPBCD_DIR_RST 8'h00
`define GPBCD_HDRV_RST 8'h00
`define GPBCD_HDRV_LO 2
`define GPBCD_HDRV_HI 5
`define GPBCD_PPI_PEND_BIT 7
`define GPBCD_PPI_SRC_LO 0
`define GPBCD_PPI_SRC_HI 1
`define GPBCD_PPI_SRC_PIN 2'h1
`define GPBCD_ADC_CH_B4 5'h04
`define GPBCD_ADC_CH_B5 5'h05
`define GPBCD_ELS_GPIO 2'h0
`endif

//--- rtl/gpbcd_pkg.sv
// Purpose: types shared by the port block and its bench
// Assumes: constants live in gpbcd_map.svh
// Notes: pin drive and timer channel carriers
package gpbcd_pkg;
   typedef struct packed {
      logic [7:0] out;
      logic [7:0] oe;
   } gpbcd_pin_drv_t;
   typedef struct packed {
      logic [1:0] els;
      logic out;
      logic oe;
   } gpbcd_tmr_ch_t;
endpackage

//--- rtl/gpbcd_ports.sv
// Purpose: ports B, C and D with data latches, direction and pin sharing
// Assumes: pins are asynchronous; pin drive is registered one cycle
// Notes: APB slave, zero wait, unmapped addresses answer with pslverr
`include "gpbcd_map.svh"

// Notes on behaviour
// - Direction bit one enables the pin's output buffer; zero makes it input.
// - Reset clears all direction bits of ports B, C and D.
// - Reset leaves the port data latches unchanged.
// - Port B data read returns the latch bit where direction is one.
// - Where direction is zero, a data read returns the sampled pin level.
// - Data writes with pstrb bit 0 set update the latch whatever the direction; input readback stays the pin.
// - Port C data has its own address and the same read rule.
// - ADC channel select of B4 or B5 overrides the port logic there.
// - Timer 1 edge/level select gives B2 and B3 to the timer.
// - Timer 2 edge/level select gives B4 and B5 to the timer.
// - B2 is the periodic interrupt clock input when clock source is 01 and timer 1 does not own B2.
// - LCD enable gives B6 and B7 to frontplanes 1 and 2.
// - Port C high and low groups go to frontplanes under their enables with LCD enable.
// - Port D enable with LCD enable gives all D pins to frontplanes.
// - High-current bits on B5..B2 act only while the pin is output.
// - Port D data has its own address and the same read rule.
module gpbcd_ports (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic arst_n,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Pins
   input wire logic [7:0] pinInB,
   input wire logic [7:0] pinInC,
   input wire logic [7:0] pinInD,
   output gpbcd_pkg::gpbcd_pin_drv_t pinDrvB,
   output gpbcd_pkg::gpbcd_pin_drv_t pinDrvC,
   output gpbcd_pkg::gpbcd_pin_drv_t pinDrvD,
   output logic [3:0] highDrive,
   // Sharing controls from other modules
   input wire logic [4:0] adcChannelSelect,
   input gpbcd_pkg::gpbcd_tmr_ch_t timerCh [3:0],
   input wire logic lcdEnable,
   input wire logic portCHighLcdEnable,
   input wire logic portCLowLcdEnable,
   input wire logic portDLcdEnable,
   input wire logic [23:0] lcdFrontplaneOutputs,
   input wire logic periodicIrqPendingLatch,
   // Sensed pin levels and clock source select for other modules
   output logic [3:0] timerCaptureIn,
   output logic periodicIrqExtClockPin,
   output logic [1:0] periodicIrqClockSource
);

   // Read mix: latch on outputs, pin level on inputs
   function automatic logic [7:0] readMix(input logic [7:0] dir, input logic [7:0] lat,
                                          input logic [7:0] pin);
      readMix = (dir & lat) | (~dir & pin);
   endfunction

   // Owner wins: alternate function drive, else latch and direction
   function automatic gpbcd_pkg::gpbcd_pin_drv_t pinMux(input logic [7:0] own,
      input logic [7:0] aOut, input logic [7:0] aOe,
      input logic [7:0] lat, input logic [7:0] dir);
      gpbcd_pkg::gpbcd_pin_drv_t r;
      r.out = (own & aOut) | (~own & lat);
      r.oe = (own & aOe) | (~own & dir);
      pinMux = r;
   endfunction

   logic [7:0] latchB_q, latchC_q, latchD_q;
   logic [7:0] dirB_q, dirC_q, dirD_q;
   logic [7:0] hdrv_q;
   logic [7:0] metaB_q, metaC_q, metaD_q;
   logic [7:0] syncB_q, syncC_q, syncD_q;
   gpbcd_pkg::gpbcd_pin_drv_t drvB_q, drvC_q, drvD_q;
   logic [3:0] highDrive_q;
   logic ppiClk_q;
   logic [31:0] prdata_q;
   logic pready_q, pslverr_q;

   // Bus decode
   wire logic setupPh = psel & ~penable;
   wire logic accessWr = psel & penable & pwrite & pready_q & pstrb[0];
   wire logic [5:0] regIdx = paddr[7:2];
   wire logic aligned = (paddr[1:0] == 2'h0);
   wire logic hitDataB = aligned & (regIdx == `GPBCD_IDX_DATA_B);
   wire logic hitDataC = aligned & (regIdx == `GPBCD_IDX_DATA_C);
   wire logic hitDataD = aligned & (regIdx == `GPBCD_IDX_DATA_D);
   wire logic hitDirB = aligned & (regIdx == `GPBCD_IDX_DIR_B);
   wire logic hitDirC = aligned & (regIdx == `GPBCD_IDX_DIR_C);
   wire logic hitDirD = aligned & (regIdx == `GPBCD_IDX_DIR_D);
   wire logic hitHdrv = aligned & (regIdx == `GPBCD_IDX_HDRV_B);
   wire logic hitAny = hitDataB | hitDataC | hitDataD | hitDirB | hitDirC | hitDirD | hitHdrv;

   wire logic [7:0] readB = readMix(dirB_q, latchB_q, syncB_q);
   wire logic [7:0] readC = readMix(dirC_q, latchC_q, syncC_q);
   wire logic [7:0] readD = readMix(dirD_q, latchD_q, syncD_q);

   // Pending flag is live state of the periodic interrupt module
   wire logic [7:0] hdrvRead = {periodicIrqPendingLatch, hdrv_q[6:0]};

   wire logic [7:0] rdSel =
      hitDataB ? readB :
      hitDataC ? readC :
      hitDataD ? readD :
      hitDirB ? dirB_q :
      hitDirC ? dirC_q :
      hitDirD ? dirD_q :
      hitHdrv ? hdrvRead : 8'h00;

   wire logic [1:0] ppiSrc = hdrv_q[`GPBCD_PPI_SRC_HI:`GPBCD_PPI_SRC_LO];

   // analog selection of B4 and B5
   wire logic adcB4 = (adcChannelSelect == `GPBCD_ADC_CH_B4);
   wire logic adcB5 = (adcChannelSelect == `GPBCD_ADC_CH_B5);

   logic [3:0] tmrOwn, tmrOut, tmrOe;
   always_comb begin
      for (int i = 0; i < 4; i++) begin
         tmrOwn[i] = (timerCh[i].els != `GPBCD_ELS_GPIO);
         tmrOut[i] = timerCh[i].out;
         tmrOe[i] = timerCh[i].oe;
      end
   end

   // external clock senses B2 with output held off
   wire logic ppiOwn = (ppiSrc == `GPBCD_PPI_SRC_PIN) & ~tmrOwn[0];

   wire logic lcdB = lcdEnable;
   wire logic lcdCHi = lcdEnable & portCHighLcdEnable;
   wire logic lcdCLo = lcdEnable & portCLowLcdEnable;
   wire logic lcdD = lcdEnable & portDLcdEnable;

   // owner masks and alternate drive per port
   wire logic [7:0] ownB = {lcdB, lcdB, adcB5 | tmrOwn[3], adcB4 | tmrOwn[2],
                            tmrOwn[1], tmrOwn[0] | ppiOwn, 2'b00};
   wire logic [7:0] altOutB = {lcdFrontplaneOutputs[1:0], tmrOut, 2'b00};
   wire logic [7:0] altOeB = {2'b11, tmrOe[3] & ~adcB5, tmrOe[2] & ~adcB4,
                              tmrOe[1], tmrOe[0] & ~ppiOwn, 2'b00};
   wire logic [7:0] ownC = {2'b00, lcdCHi, lcdCHi, {4{lcdCLo}}};
   wire logic [7:0] altOutC = {2'b00, lcdFrontplaneOutputs[23:18]};
   wire logic [7:0] altOeC = 8'h3F;
   wire logic [7:0] ownD = {8{lcdD}};
   wire logic [7:0] altOutD = lcdFrontplaneOutputs[17:10];

   // buffer enable from direction unless owned
   wire gpbcd_pkg::gpbcd_pin_drv_t drvB_d = pinMux(ownB, altOutB, altOeB, latchB_q, dirB_q);
   wire gpbcd_pkg::gpbcd_pin_drv_t drvC_d = pinMux(ownC, altOutC, altOeC, latchC_q, dirC_q);
   wire gpbcd_pkg::gpbcd_pin_drv_t drvD_d = pinMux(ownD, altOutD, 8'hFF, latchD_q, dirD_q);

   // high current only on a driven output
   wire logic [3:0] highDrive_d = hdrv_q[`GPBCD_HDRV_HI:`GPBCD_HDRV_LO]
                                  & drvB_d.oe[5:2] & ~ownB[5:2];

   // latches have no reset so they survive it
   // write updates latch whatever the direction
   always_ff @(posedge sys_clk) begin
      if (accessWr & hitDataB) begin
         latchB_q <= pwdata[7:0];
      end
      if (accessWr & hitDataC) begin
         latchC_q <= pwdata[7:0];
      end
      if (accessWr & hitDataD) begin
         latchD_q <= pwdata[7:0];
      end
   end

   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         dirB_q <= `GPBCD_DIR_RST;
         dirC_q <= `GPBCD_DIR_RST;
         dirD_q <= `GPBCD_DIR_RST;
         hdrv_q <= `GPBCD_HDRV_RST;
      end else begin
         if (accessWr & hitDirB) begin
            dirB_q <= pwdata[7:0];
         end
         if (accessWr & hitDirC) begin
            dirC_q <= pwdata[7:0];
         end
         if (accessWr & hitDirD) begin
            dirD_q <= pwdata[7:0];
         end
         if (accessWr & hitHdrv) begin
            hdrv_q <= {1'b0, pwdata[6:0]};
         end
      end
   end

   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         metaB_q <= 8'h00;
         metaC_q <= 8'h00;
         metaD_q <= 8'h00;
         syncB_q <= 8'h00;
         syncC_q <= 8'h00;
         syncD_q <= 8'h00;
      end else begin
         metaB_q <= pinInB;
         metaC_q <= pinInC;
         metaD_q <= pinInD;
         syncB_q <= metaB_q;
         syncC_q <= metaC_q;
         syncD_q <= metaD_q;
      end
   end

   // Registered pin drive keeps decode glitches off the pads
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         drvB_q <= '0;
         drvC_q <= '0;
         drvD_q <= '0;
         highDrive_q <= 4'h0;
         ppiClk_q <= 1'b0;
      end else begin
         drvB_q <= drvB_d;
         drvC_q <= drvC_d;
         drvD_q <= drvD_d;
         highDrive_q <= highDrive_d;
         // sensed clock forwarded only when selected
         ppiClk_q <= ppiOwn & syncB_q[2];
      end
   end

   // Answer prepared in setup so access completes without wait
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         prdata_q <= 32'h0000_0000;
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
      end else begin
         pready_q <= setupPh;
         pslverr_q <= setupPh & ~hitAny;
         if (setupPh & ~pwrite) begin
            prdata_q <= {24'h00_0000, rdSel};
         end
      end
   end

   assign prdata = prdata_q;
   assign pready = pready_q;
   assign pslverr = pslverr_q;
   assign pinDrvB = drvB_q;
   assign pinDrvC = drvC_q;
   assign pinDrvD = drvD_q;
   assign highDrive = highDrive_q;
   assign timerCaptureIn = syncB_q[5:2];
   assign periodicIrqExtClockPin = ppiClk_q;
   assign periodicIrqClockSource = ppiSrc;

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!arst_n);

   chk_dir_reset: assert property (
      !$past(arst_n) |-> (dirB_q == 8'h00 && dirC_q == 8'h00 && dirD_q == 8'h00))
      else $error("direction not cleared by reset");

   chk_buffer_enable: assert property (
      (ownC == 8'h00 && $stable(dirC_q)) |=> drvC_q.oe == $past(dirC_q))
      else $error("port C buffer enable differs from direction");

   chk_read_portb: assert property (
      (setupPh && !pwrite && hitDataB) |=> pready && prdata[7:0] ==
      (($past(dirB_q) & $past(latchB_q)) | (~$past(dirB_q) & $past(syncB_q))))
      else $error("port B readback wrong");

   chk_read_portc: assert property (
      (setupPh && !pwrite && hitDataC && dirC_q == 8'h00) |=> prdata[7:0] == $past(syncC_q))
      else $error("port C input readback wrong");

   chk_read_portd: assert property (
      (setupPh && !pwrite && hitDataD && dirD_q == 8'hFF) |=> prdata[7:0] == $past(latchD_q))
      else $error("port D output readback wrong");

   chk_write_latch: assert property (
      (accessWr && hitDataB) |=> latchB_q == $past(pwdata[7:0]))
      else $error("port B latch not written");

   chk_adc_override: assert property (
      (adcB4 && $stable(adcChannelSelect)) |=> !drvB_q.oe[4] && !highDrive_q[2])
      else $error("analog pin B4 still driven");

   chk_timer_own: assert property (
      tmrOwn[0] |=> drvB_q.out[2] == $past(tmrOut[0]) && drvB_q.oe[2] == $past(tmrOe[0]))
      else $error("timer 1 channel 0 not on B2");

   chk_lcd_portb: assert property (
      lcdEnable |=> drvB_q.oe[7:6] == 2'b11 && drvB_q.out[7:6] == $past(lcdFrontplaneOutputs[1:0]))
      else $error("frontplane 1 or 2 not driven");

   chk_sync_depth: assert property (
      $stable(pinInD) [*3] |-> syncD_q == $past(pinInD, 2))
      else $error("port D synchroniser depth wrong");

   chk_buffer_portd: assert property (
      (ownD == 8'h00) |=> drvD_q.oe == $past(dirD_q))
      else $error("port D buffer enable differs from direction");

   chk_read_input: assert property (
      (setupPh && !pwrite && hitDataC) |=>
      (prdata[7:0] & ~$past(dirC_q)) == ($past(syncC_q) & ~$past(dirC_q)))
      else $error("port C input bits do not show the pin");

   chk_read_output: assert property (
      (setupPh && !pwrite && hitDataC) |=> (prdata[7:0] & $past(dirC_q)) == ($past(latchC_q) & $past(dirC_q)))
      else $error("port C output bits do not show the latch");

   chk_write_latch_d: assert property (
      (accessWr && hitDataD) |=> latchD_q == $past(pwdata[7:0]))
      else $error("port D latch not written");

   chk_timer2_own: assert property (
      (tmrOwn[3] && !adcB5) |=> drvB_q.out[5] == $past(tmrOut[3]) && drvB_q.oe[5] == $past(tmrOe[3]))
      else $error("timer 2 channel 1 not on B5");

   // external clock pin sensed, buffer off
   chk_ppi_clock: assert property (
      ppiOwn |=> !drvB_q.oe[2] && periodicIrqExtClockPin == $past(syncB_q[2]))
      else $error("periodic clock pin not sensed");

   chk_lcd_low_group: assert property (
      lcdCLo |=> drvC_q.oe[3:0] == 4'hF && drvC_q.out[3:0] == $past(lcdFrontplaneOutputs[21:18]))
      else $error("frontplanes 19 to 22 not driven");

   chk_lcd_high_group: assert property (
      lcdCHi |=> drvC_q.oe[5:4] == 2'b11 && drvC_q.out[5:4] == $past(lcdFrontplaneOutputs[23:22]))
      else $error("frontplanes 23 or 24 not driven");

   // port D frontplanes ignore latch and direction
   chk_lcd_portd: assert property (
      lcdD |=> drvD_q.oe == 8'hFF && drvD_q.out == $past(lcdFrontplaneOutputs[17:10]))
      else $error("frontplanes 11 to 18 not driven");

   // high drive only on an unowned output
   chk_high_drive: assert property (
      (ownB[5:2] == 4'h0) |=> highDrive_q == ($past(hdrv_q[5:2]) & $past(dirB_q[5:2])))
      else $error("high drive differs from enable and direction");

endmodule // gpbcd_ports

//--- tb/gpbcd_board.sv
// Purpose: board around the port pins
// Assumes: a driven pin shows the chip level
// Notes: no pulls, so undriven pins take the outside level
module gpbcd_board (
   // Chip drive
   input gpbcd_pkg::gpbcd_pin_drv_t drvB,
   input gpbcd_pkg::gpbcd_pin_drv_t drvC,
   input gpbcd_pkg::gpbcd_pin_drv_t drvD,
   // Outside levels
   input wire logic [7:0] extB,
   input wire logic [7:0] extC,
   input wire logic [7:0] extD,
   // Pin levels
   output logic [7:0] pinB,
   output logic [7:0] pinC,
   output logic [7:0] pinD
);
   timeunit 1ns;
   timeprecision 1ps;
   assign pinB = (drvB.out & drvB.oe) | (extB & ~drvB.oe);
   assign pinC = (drvC.out & drvC.oe) | (extC & ~drvC.oe);
   assign pinD = (drvD.out & drvD.oe) | (extD & ~drvD.oe);
endmodule // gpbcd_board

//--- tb/gpio_ports_b_c_d_test.sv
// Purpose: bench for ports B, C and D
// Assumes: zero wait APB; pins pass two flops
// Notes: board model closes the pin loop
`include "gpbcd_map.svh"
module gpio_ports_b_c_d_test;
   timeunit 1ns;
   timeprecision 1ps;
   logic sys_clk = 1'b0;
   logic arst_n, psel, penable, pwrite, pready, pslverr, err, ppiPend, ppiCk;
   logic lcdEnable, cHiEn, cLoEn, dEn;
   logic [7:0] paddr, extB, extC, extD, pinInB, pinInC, pinInD, dataA, dirA;
   logic [31:0] pwdata, prdata, rd;
   logic [3:0] pstrb, highDrive, capIn;
   logic [1:0] ppiSrc;
   logic [4:0] adcSel;
   logic [23:0] lcdFp;
   gpbcd_pkg::gpbcd_pin_drv_t pinDrvB, pinDrvC, pinDrvD, drv;
   gpbcd_pkg::gpbcd_tmr_ch_t timerCh [3:0];
   int n_errors = 0;
   int samples_checked = 0;
   localparam logic [7:0] HDRV = {`GPBCD_IDX_HDRV_B, 2'b00};
   localparam logic [7:0] DIRB = {`GPBCD_IDX_DIR_B, 2'b00};
   gpbcd_ports dut (.sys_clk(sys_clk), .arst_n(arst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .pinInB(pinInB), .pinInC(pinInC), .pinInD(pinInD), .pinDrvB(pinDrvB), .pinDrvC(pinDrvC),
      .pinDrvD(pinDrvD), .highDrive(highDrive), .adcChannelSelect(adcSel), .timerCh(timerCh),
      .lcdEnable(lcdEnable), .portCHighLcdEnable(cHiEn), .portCLowLcdEnable(cLoEn), .portDLcdEnable(dEn),
      .lcdFrontplaneOutputs(lcdFp), .periodicIrqPendingLatch(ppiPend), .timerCaptureIn(capIn),
      .periodicIrqExtClockPin(ppiCk), .periodicIrqClockSource(ppiSrc));
   gpbcd_board board (.drvB(pinDrvB), .drvC(pinDrvC), .drvD(pinDrvD), .extB(extB), .extC(extC),
      .extD(extD), .pinB(pinInB), .pinC(pinInC), .pinD(pinInD));
   always #4 sys_clk = ~sys_clk;
   task automatic cyc(input int n);
      repeat (n) @(posedge sys_clk);
   endtask
   task automatic chk(input string w, input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         n_errors++;
         $display("CHECK FAILED %s expected %h seen %h", w, exp, seen);
      end
   endtask
   // Request held until pready is sampled high at a rising edge
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge sys_clk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge sys_clk);
      penable <= 1'b1;
      do begin
         @(posedge sys_clk);
      end while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic rdc(input string w, input logic [7:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      chk(w, rd, e);
   endtask
   task automatic report_and_stop();
      $display("errors %0d checks %0d", n_errors, samples_checked);
      if (n_errors == 0 && samples_checked > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   initial begin
      cyc(3000);
      n_errors++;
      report_and_stop();
   end
   initial begin
      arst_n = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      pstrb = 4'hF;
      extB = 8'h3C;
      extC = 8'h3C;
      extD = 8'h3C;
      adcSel = 5'h00;
      lcdFp = 24'hA5C33C;
      lcdEnable = 1'b0;
      cHiEn = 1'b0;
      cLoEn = 1'b0;
      dEn = 1'b0;
      ppiPend = 1'b1;
      for (int i = 0; i < 4; i++) timerCh[i] = '0;
      cyc(2);
      arst_n <= 1'b1;
      for (int p = 0; p < 3; p++) begin
         dataA = {`GPBCD_IDX_DATA_B + 6'(p), 2'b00};
         dirA = {`GPBCD_IDX_DIR_B + 6'(p), 2'b00};
         apb(1'b1, dataA, 32'hA5);
         apb(1'b1, dirA, 32'h0F);
         cyc(3);
         rdc("data", dataA, 32'h35);
         drv = p == 0 ? pinDrvB : p == 1 ? pinDrvC : pinDrvD;
         chk("oe", drv.oe, 8'h0F);
         chk("out", drv.out & 8'h0F, 8'h05);
         apb(1'b1, dataA, 32'h5A);
         rdc("inrd", dataA, 32'h3A);
      end
      arst_n <= 1'b0;
      cyc(2);
      arst_n <= 1'b1;
      chk("oeB", pinDrvB.oe, 8'h00);
      for (int p = 0; p < 3; p++) begin
         dataA = {`GPBCD_IDX_DATA_B + 6'(p), 2'b00};
         dirA = {`GPBCD_IDX_DIR_B + 6'(p), 2'b00};
         rdc("dir", dirA, 32'h0);
         apb(1'b1, dirA, 32'hFF);
         rdc("latch", dataA, 32'h5A);
      end
      apb(1'b1, HDRV, 32'hFF);
      rdc("hdReg", HDRV, 32'hFF);
      apb(1'b1, HDRV, 32'h3C);
      cyc(2);
      chk("hd", highDrive, 4'hF);
      apb(1'b1, DIRB, 32'hC3);
      cyc(2);
      chk("hd", highDrive, 4'h0);
      apb(1'b1, HDRV, {30'h0, `GPBCD_PPI_SRC_PIN});
      extB <= 8'h04;
      cyc(4);
      chk("src", ppiSrc, 2'h1);
      chk("oeB2", pinDrvB.oe[2], 1'b0);
      chk("ppiCk", ppiCk, 1'b1);
      extB <= 8'h00;
      cyc(4);
      chk("ppiCk", ppiCk, 1'b0);
      apb(1'b1, HDRV, 32'h00);
      apb(1'b1, DIRB, 32'h00);
      timerCh[0] <= '{2'h1, 1'b1, 1'b1};
      timerCh[3] <= '{2'h2, 1'b1, 1'b1};
      extB <= 8'h08;
      cyc(4);
      chk("tmrOe", pinDrvB.oe, 8'h24);
      chk("tmrOut", pinDrvB.out & 8'h24, 8'h24);
      chk("cap", capIn, 4'hB);
      timerCh[2] <= '{2'h3, 1'b1, 1'b1};
      for (int k = 0; k < 2; k++) begin
         adcSel <= `GPBCD_ADC_CH_B4 + 5'(k);
         cyc(3);
         chk("adcOe", pinDrvB.oe[5:4], k ? 2'b01 : 2'b10);
      end
      adcSel <= 5'h00;
      apb(1'b1, {`GPBCD_IDX_DIR_C, 2'b00}, 32'h00);
      lcdEnable <= 1'b1;
      cHiEn <= 1'b1;
      cLoEn <= 1'b1;
      dEn <= 1'b1;
      cyc(3);
      chk("fpB", {pinDrvB.out[7:6], pinDrvB.oe[7:6]}, {lcdFp[1:0], 2'b11});
      chk("fpC", {pinDrvC.out[5:0], pinDrvC.oe[5:0]}, {lcdFp[23:18], 6'h3F});
      chk("fpD", {pinDrvD.out, pinDrvD.oe}, {lcdFp[17:10], 8'hFF});
      cHiEn <= 1'b0;
      cyc(3);
      chk("fpCLo", pinDrvC.oe[5:0], 6'h0F);
      lcdEnable <= 1'b0;
      cyc(3);
      chk("lcdOffC", pinDrvC.oe, 8'h00);
      chk("lcdOffD", pinDrvD.out, 8'h5A);
      rdc("inC", {`GPBCD_IDX_DATA_C, 2'b00}, 32'h3C);
      // Unmapped place is refused
      rdc("unmapped", 8'hFC, 32'h0);
      chk("slverr", err, 1'b1);
      report_and_stop();
   end
endmodule // gpio_ports_b_c_d_test
